// file: ppi_port_regs.vh
// constants for the port pin integration block
`ifndef PPI_PORT_REGS_VH
`define PPI_PORT_REGS_VH

// ****************************************
// reset values (per bit, replicated)
// ****************************************
`define PPI_RST_IO 1'b0
`define PPI_RST_DDR 1'b0
`define PPI_RST_DRIVE_REDUCE 1'b0
`define PPI_RST_POLARITY 1'b0
`define PPI_RST_WOM 1'b0
`define PPI_RST_IRQ_ENABLE 1'b0
`define PPI_RST_IRQ_FLAG 1'b0
`define PPI_RST_PULL_ON 1'b1
`define PPI_RST_PULL_OFF 1'b0

// ****************************************
// field encodings
// ****************************************
`define PPI_DIR_INPUT 1'b0
`define PPI_DIR_OUTPUT 1'b1
`define PPI_POL_FALL_PULLUP 1'b0
`define PPI_POL_RISE_PULLDOWN 1'b1
`define PPI_ANALOG_READ 1'b1

// ****************************************
// glitch filter timing
// ****************************************
`define PPI_FLT_SAMPLES 3'h4
`define PPI_CLK_PERIOD_NS 10
`define PPI_RC_PERIOD_NS 2000
`define PPI_RC_CYCLES (`PPI_RC_PERIOD_NS / `PPI_CLK_PERIOD_NS)
`define PPI_STOP_IGNORE_NS 3200
`define PPI_STOP_VALID_NS 10000

`endif

// file: ppi_port.v
// port pin integration: pin muxing, pad control, readback and edge interrupts
// Functional notes
// - enabled peripheral overrides gpio and direction bit
// - pwm over spi, can over two-wire, over gpio
// - serial units or timer over gpio use
// - output register reaches pin only as gpio output
// - io readback: pin when input, register when output
// - readbacks settle within four cycles after direction change
// - read-only pin register, synchronized pin level, 1 on analog pins
// - direction 0 input, 1 output
// - analog enable kills drive, digital input reads 1
// - reduced drive only acts on outputs
// - pull only on input or wired-or output
// - polarity picks edge and pull-up or pull-down
// - writes always accepted, take effect when allowed
// - per-pin edge interrupts, one request per port
// - request when flag and enable both set
// - run mode filter: 3 ignored, 4 accepted
// - stop mode filter: 3.2us ignored, 10us accepted
// - edge needs 4 passive then 4 active samples
// - bus clock samples in run, rc in stop
// - rc runs only while a pin still arms
// - reset clears registers except pull enable (per PULL_AT_RESET) and pull-up output, reads synchronized
// - reset: inputs, no reduced drive, irqs off
// - active edge sets flag, write one clears
// - can forces tx out, rx in, direction untouched
`include "ppi_port_regs.vh"

module ppi_port #(
  parameter WIDTH = 8,
  parameter HAS_IRQ = 1,
  parameter PULL_AT_RESET = 0
) (
  input wire I_CLK_SYS,
  input wire I_RESETN,
  input wire i_STOP_MODE,
  input wire [WIDTH-1:0] i_WDATA,
  input wire i_WR_IO,
  input wire i_WR_DDR,
  input wire i_WR_DRIVE_REDUCE,
  input wire i_WR_PULL_ENABLE,
  input wire i_WR_PULL_POLARITY,
  input wire i_WR_WOM,
  input wire i_WR_IRQ_ENABLE,
  input wire i_WR_IRQ_FLAG,
  input wire [WIDTH-1:0] i_HI_EN,
  input wire [WIDTH-1:0] i_HI_DOUT,
  input wire [WIDTH-1:0] i_HI_OE,
  input wire [WIDTH-1:0] i_MID_EN,
  input wire [WIDTH-1:0] i_MID_DOUT,
  input wire [WIDTH-1:0] i_MID_OE,
  input wire [WIDTH-1:0] i_ANALOG_EN,
  input wire [WIDTH-1:0] i_PIN_IN,
  output reg [WIDTH-1:0] o_PIN_OUT,
  output reg [WIDTH-1:0] o_PIN_OE,
  output reg [WIDTH-1:0] o_DRIVE_REDUCE,
  output reg [WIDTH-1:0] o_PULL_EN,
  output reg [WIDTH-1:0] o_PULL_UP,
  output reg [WIDTH-1:0] o_PERIPH_DIN,
  output reg [WIDTH-1:0] o_RD_IO,
  output reg [WIDTH-1:0] o_RD_PIN,
  output reg [WIDTH-1:0] o_RD_IRQ_FLAG,
  output reg o_IRQ,
  output reg o_RC_OSC_RUN
);

  localparam integer RC_DIV = `PPI_RC_CYCLES;
  localparam [7:0] RC_LAST = RC_DIV[7:0] - 8'h01;
  localparam [0:0] PULL_RST_BIT = (PULL_AT_RESET != 0) ? `PPI_RST_PULL_ON : `PPI_RST_PULL_OFF;
  localparam [0:0] IRQ_ON = (HAS_IRQ != 0) ? 1'b1 : 1'b0;
  localparam [2:0] FLT_LAST = `PPI_FLT_SAMPLES - 3'h1;

  // ****************************************
  // data and direction registers
  // ****************************************
  reg [WIDTH-1:0] io_reg;
  reg [WIDTH-1:0] ddr;
  reg [WIDTH-1:0] drive_reduce_bit;
  reg [WIDTH-1:0] pull_enable_bit;
  reg [WIDTH-1:0] pull_polarity_bit;
  reg [WIDTH-1:0] wom;
  reg [WIDTH-1:0] pin_irq_enable;
  reg [WIDTH-1:0] pin_irq_flag;

  // writes land regardless of how the pin is used
  always @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      io_reg <= {WIDTH{`PPI_RST_IO}};
    end else if (i_WR_IO) begin
      io_reg <= i_WDATA;
    end
  end

  always @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      ddr <= {WIDTH{`PPI_RST_DDR}};
    end else if (i_WR_DDR) begin
      ddr <= i_WDATA;
    end
  end

  // ****************************************
  // pad configuration registers
  // ****************************************
  always @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      drive_reduce_bit <= {WIDTH{`PPI_RST_DRIVE_REDUCE}};
    end else if (i_WR_DRIVE_REDUCE) begin
      drive_reduce_bit <= i_WDATA;
    end
  end

  always @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      pull_enable_bit <= {WIDTH{PULL_RST_BIT}};
    end else if (i_WR_PULL_ENABLE) begin
      pull_enable_bit <= i_WDATA;
    end
  end

  always @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      pull_polarity_bit <= {WIDTH{`PPI_RST_POLARITY}};
    end else if (i_WR_PULL_POLARITY) begin
      pull_polarity_bit <= i_WDATA;
    end
  end

  always @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      wom <= {WIDTH{`PPI_RST_WOM}};
    end else if (i_WR_WOM) begin
      wom <= i_WDATA;
    end
  end

  // ****************************************
  // interrupt enable register
  // ****************************************
  always @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      pin_irq_enable <= {WIDTH{`PPI_RST_IRQ_ENABLE}};
    end else if (i_WR_IRQ_ENABLE) begin
      pin_irq_enable <= i_WDATA & {WIDTH{IRQ_ON}};
    end
  end

  // ****************************************
  // pin synchronizer
  // ****************************************
  reg [WIDTH-1:0] pin_meta;
  reg [WIDTH-1:0] pin_sync;

  // only the second stage reads the first, so a metastable level never fans out
  always @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      pin_meta <= {WIDTH{1'b0}};
      pin_sync <= {WIDTH{1'b0}};
    end else begin
      pin_meta <= i_PIN_IN;
      pin_sync <= pin_meta;
    end
  end

  // ****************************************
  // stop mode rc sample clock
  // ****************************************
  reg [7:0] rc_cnt;
  reg rc_tick;
  wire [WIDTH-1:0] pin_arming;
  wire rc_needed;
  wire sample_en;

  // a divider stands in for the rc; it only ticks while someone can still arm
  // a longer period saves power but widens the stop mode filter window
  assign rc_needed = i_STOP_MODE & (|pin_arming);

  always @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      rc_cnt <= 8'h00;
      rc_tick <= 1'b0;
    end else if (!rc_needed) begin
      rc_cnt <= 8'h00;
      rc_tick <= 1'b0;
    end else if (rc_cnt == RC_LAST) begin
      rc_cnt <= 8'h00;
      rc_tick <= 1'b1;
    end else begin
      rc_cnt <= rc_cnt + 8'h01;
      rc_tick <= 1'b0;
    end
  end

  assign sample_en = i_STOP_MODE ? rc_tick : 1'b1;

  // ****************************************
  // per pin muxing and filter
  // ****************************************
  wire [WIDTH-1:0] next_out;
  wire [WIDTH-1:0] next_oe;
  wire [WIDTH-1:0] next_reduce;
  wire [WIDTH-1:0] next_pull_en;
  wire [WIDTH-1:0] next_pull_up;
  wire [WIDTH-1:0] dig_in;
  wire [WIDTH-1:0] edge_hit;
  wire [WIDTH-1:0] io_view;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : pin
      wire own_hi;
      wire own_mid;
      wire hi_dir;
      wire eff_dout;
      wire eff_dir;
      wire active_lvl;
      wire smp_active;
      reg [2:0] pass_cnt;
      reg [2:0] act_cnt;
      reg armed;

      assign own_hi = i_HI_EN[g];
      assign own_mid = i_MID_EN[g] & ~own_hi;
      // can on the high slot supplies its own tx/rx directions
      assign hi_dir = i_HI_OE[g];
      // peripheral owns the pin: direction bit stays and is ignored by the pad, but io readback still follows it
      assign eff_dout = own_hi ? i_HI_DOUT[g] : (own_mid ? i_MID_DOUT[g] : io_reg[g]);
      assign eff_dir = own_hi ? hi_dir : (own_mid ? i_MID_OE[g] : ddr[g]);
      assign next_out[g] = eff_dout;
      // wired-or only pulls low; a high level releases the pad
      assign next_oe[g] = (eff_dir == `PPI_DIR_OUTPUT) & ~i_ANALOG_EN[g] & ~(wom[g] & eff_dout);
      assign next_reduce[g] = drive_reduce_bit[g] & eff_dir;
      assign next_pull_en[g] = pull_enable_bit[g] & (~eff_dir | wom[g]);
      // polarity also picks the pull direction on peripheral-owned pins
      assign next_pull_up[g] = (pull_polarity_bit[g] == `PPI_POL_FALL_PULLUP);
      assign dig_in[g] = i_ANALOG_EN[g] ? `PPI_ANALOG_READ : pin_sync[g];
      assign io_view[g] = ddr[g] ? io_reg[g] : dig_in[g];

      assign active_lvl = (pull_polarity_bit[g] == `PPI_POL_RISE_PULLDOWN);
      assign smp_active = (dig_in[g] == active_lvl);
      assign edge_hit[g] = IRQ_ON & sample_en & smp_active & armed & (act_cnt == FLT_LAST);
      // counts saturate at four, so the count term always holds
      assign pin_arming[g] = pin_irq_enable[g] & ~pin_irq_flag[g] & (act_cnt <= `PPI_FLT_SAMPLES);

      // filter watches the pin whatever its direction
      always @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
          act_cnt <= 3'h0;
        end else if (sample_en) begin
          if (!smp_active) begin
            act_cnt <= 3'h0;
          end else if (act_cnt != `PPI_FLT_SAMPLES) begin
            act_cnt <= act_cnt + 3'h1;
          end
        end
      end

      always @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
          pass_cnt <= 3'h0;
        end else if (sample_en) begin
          if (smp_active) begin
            pass_cnt <= 3'h0;
          end else if (pass_cnt != `PPI_FLT_SAMPLES) begin
            pass_cnt <= pass_cnt + 3'h1;
          end
        end
      end

      always @(posedge I_CLK_SYS) begin
        if (!I_RESETN) begin
          armed <= 1'b0;
        end else if (edge_hit[g]) begin
          armed <= 1'b0;
        end else if (sample_en & ~smp_active & (pass_cnt == FLT_LAST)) begin
          armed <= 1'b1;
        end
      end
    end
  endgenerate

  // ****************************************
  // interrupt flags
  // ****************************************
  // a new edge in the clearing cycle keeps the flag set
  always @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      pin_irq_flag <= {WIDTH{`PPI_RST_IRQ_FLAG}};
    end else begin
      pin_irq_flag <= (pin_irq_flag & ~({WIDTH{i_WR_IRQ_FLAG}} & i_WDATA)) | edge_hit;
    end
  end

  // ****************************************
  // registered pad outputs
  // ****************************************
  always @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      o_PIN_OUT <= {WIDTH{1'b0}};
      o_PIN_OE <= {WIDTH{1'b0}};
      o_DRIVE_REDUCE <= {WIDTH{1'b0}};
      o_PULL_EN <= {WIDTH{PULL_RST_BIT}};
      o_PULL_UP <= {WIDTH{1'b1}};
    end else begin
      o_PIN_OUT <= next_out;
      o_PIN_OE <= next_oe;
      o_DRIVE_REDUCE <= next_reduce;
      o_PULL_EN <= next_pull_en;
      o_PULL_UP <= next_pull_up;
    end
  end

  // ****************************************
  // registered readbacks
  // ****************************************
  // io readback lags a direction change by one cycle; pin readbacks lag it by four
  always @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      o_PERIPH_DIN <= {WIDTH{1'b0}};
      o_RD_IO <= {WIDTH{1'b0}};
      o_RD_PIN <= {WIDTH{1'b0}};
      o_RD_IRQ_FLAG <= {WIDTH{1'b0}};
    end else begin
      o_PERIPH_DIN <= dig_in;
      o_RD_IO <= io_view;
      o_RD_PIN <= dig_in;
      o_RD_IRQ_FLAG <= pin_irq_flag;
    end
  end

  // ****************************************
  // request and oscillator status
  // ****************************************
  always @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      o_IRQ <= 1'b0;
      o_RC_OSC_RUN <= 1'b0;
    end else begin
      o_IRQ <= |(pin_irq_flag & pin_irq_enable);
      o_RC_OSC_RUN <= rc_needed;
    end
  end

endmodule

// file: ppi_port_sva.sv
// assertion checker for the port pin integration block
module ppi_port_sva #(
  parameter WIDTH = 8
) (
  input wire I_CLK_SYS,
  input wire I_RESETN,
  input wire i_STOP_MODE,
  input wire [WIDTH-1:0] i_WDATA,
  input wire i_WR_DDR,
  input wire i_WR_IRQ_FLAG,
  input wire [WIDTH-1:0] i_HI_EN,
  input wire [WIDTH-1:0] i_MID_EN,
  input wire [WIDTH-1:0] i_ANALOG_EN,
  input wire [WIDTH-1:0] i_PIN_IN,
  input wire [WIDTH-1:0] o_PIN_OE,
  input wire [WIDTH-1:0] o_RD_IRQ_FLAG,
  input wire o_IRQ,
  input wire o_RC_OSC_RUN
);
  // ****************
  // checks
  // ****************
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESETN);
  wire quiet = !(i_HI_EN | i_MID_EN | i_ANALOG_EN);
  sequence s_dir_write;
    i_WR_DDR && quiet ##1 quiet && !i_WR_DDR;
  endsequence
  chk_reset_state: assert property ($rose(I_RESETN) |-> !(o_PIN_OE | o_RD_IRQ_FLAG) && !o_IRQ)
    else $error("outputs not idle after reset");
  chk_dir_drive: assert property (s_dir_write |=> o_PIN_OE == $past(i_WDATA, 2))
    else $error("drive enable differs from direction");
  chk_analog_drive: assert property (!(o_PIN_OE & $past(i_ANALOG_EN) & $past(i_ANALOG_EN, 2)))
    else $error("analog pin still driven");
  chk_irq_cause: assert property (o_IRQ |-> o_RD_IRQ_FLAG != {WIDTH{1'b0}})
    else $error("request without flag");
  chk_flag_clear: assert property (i_WR_IRQ_FLAG |-> ##2 !(o_RD_IRQ_FLAG & $past(i_WDATA, 2)))
    else $error("flag not cleared");
  chk_flag_hold: assert property (($past(o_RD_IRQ_FLAG) & ~o_RD_IRQ_FLAG) != {WIDTH{1'b0}} |-> $past(i_WR_IRQ_FLAG, 2))
    else $error("flag dropped without clear");
  // two samples only: the exact filter latency is left loose
  chk_filter_width: assert property ($rose(o_RD_IRQ_FLAG[0]) |-> $past(i_PIN_IN[0], 5) == $past(i_PIN_IN[0], 6))
    else $error("flag from a short pulse");
  chk_rc_idle: assert property (!i_STOP_MODE [*2] |=> !o_RC_OSC_RUN)
    else $error("oscillator runs outside stop");
endmodule
bind ppi_port ppi_port_sva #(.WIDTH(WIDTH)) u_sva (.I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN),
  .i_STOP_MODE(i_STOP_MODE), .i_WDATA(i_WDATA), .i_WR_DDR(i_WR_DDR), .i_WR_IRQ_FLAG(i_WR_IRQ_FLAG),
  .i_HI_EN(i_HI_EN), .i_MID_EN(i_MID_EN), .i_ANALOG_EN(i_ANALOG_EN), .i_PIN_IN(i_PIN_IN), .o_PIN_OE(o_PIN_OE),
  .o_RD_IRQ_FLAG(o_RD_IRQ_FLAG), .o_IRQ(o_IRQ), .o_RC_OSC_RUN(o_RC_OSC_RUN));

// file: ppi_pin_model.sv
// model of the pads and the board around them
module ppi_pin_model (
  input wire logic clk,
  input wire logic [7:0] out,
  input wire logic [7:0] oe,
  input wire logic [7:0] pen,
  input wire logic [7:0] pup,
  input wire logic [7:0] ext,
  input wire logic [7:0] xen,
  output logic [7:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // pad resolution
  // ****************
  logic [7:0] flo = 8'h00;
  // an undriven pad wanders, so a stale level never passes for a pin value
  always @(posedge clk) flo <= ~flo;
  // board driver wins, so a shorted output shows on the readback
  assign pin = xen & ext | ~xen & (oe & out | ~oe & (pen & pup | ~pen & flo));
endmodule

// file: ppi_port_tb_top.sv
// self-checking bench for the port pin integration block
module ppi_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sm = 1'b0;
  logic [7:0] wd = 8'h00, st = 8'h00, he = 8'h00, hd = 8'h00, ho = 8'h00, d, p;
  logic [7:0] me = 8'h00, md = 8'h00, mo = 8'h00, an = 8'h00, ext = 8'h00, xen = 8'h00;
  wire [7:0] pin, p_out, p_oe, pen, pup, din, rd_io, rd_pin, flg, rdc;
  wire irq, rc;
  int bad_count = 0;
  int samples_checked = 0;
  // io, direction, reduce, pull, polarity, board level, io readback, pin readback
  logic [7:0] rows [4][8] = '{'{8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hA5, 8'hA5, 8'hA5},
    '{8'h3C, 8'hFF, 8'h0F, 8'hFF, 8'h55, 8'h00, 8'h3C, 8'h3C},
    '{8'h9A, 8'hF0, 8'h33, 8'h0F, 8'h03, 8'h00, 8'h9C, 8'h9C},
    '{8'hC3, 8'h0F, 8'hFF, 8'hC0, 8'h40, 8'h2D, 8'hA3, 8'hA3}};
  ppi_port #(.PULL_AT_RESET(1)) DUT (.I_CLK_SYS(clk), .I_RESETN(rst_n), .i_STOP_MODE(sm), .i_WDATA(wd),
    .i_WR_IO(st[0]), .i_WR_DDR(st[1]), .i_WR_DRIVE_REDUCE(st[2]), .i_WR_PULL_ENABLE(st[3]),
    .i_WR_PULL_POLARITY(st[4]), .i_WR_WOM(st[5]), .i_WR_IRQ_ENABLE(st[6]), .i_WR_IRQ_FLAG(st[7]),
    .i_HI_EN(he), .i_HI_DOUT(hd), .i_HI_OE(ho), .i_MID_EN(me),
    .i_MID_DOUT(md), .i_MID_OE(mo), .i_ANALOG_EN(an), .i_PIN_IN(pin), .o_PIN_OUT(p_out), .o_PIN_OE(p_oe),
    .o_DRIVE_REDUCE(rdc), .o_PULL_EN(pen), .o_PULL_UP(pup), .o_PERIPH_DIN(din), .o_RD_IO(rd_io),
    .o_RD_PIN(rd_pin), .o_RD_IRQ_FLAG(flg), .o_IRQ(irq), .o_RC_OSC_RUN(rc));
  ppi_pin_model u_pins (.clk(clk), .out(p_out), .oe(p_oe), .pen(pen), .pup(pup), .ext(ext), .xen(xen),
    .pin(pin));
  // ****************
  // helpers
  // ****************
  initial forever #5 clk = ~clk;
  task final_report;
    $display("mismatches %0d of %0d checks", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task gap(input int n);
    repeat (n) @(negedge clk);
  endtask
  task wr(input int k, input logic [7:0] v);
    @(negedge clk) wd = v;
    st[k] = 1'b1;
    @(negedge clk) st = 8'h00;
  endtask
  task pulse(input logic lv, input int n);
    ext[0] = lv;
    gap(n);
    ext[0] = ~lv;
  endtask
  // bounded, so a stuck filter ends the run instead of hanging it
  task wait_flag(input int n);
    for (int i = 0; i < n && flg[0] !== 1'b1; i++) @(negedge clk);
    if (flg[0] !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, flg, 8'h01);
      final_report;
    end
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    gap(16);
    rst_n = 1'b1;
    gap(1);
    chk(p_oe | rdc | flg, 8'h00);
    chk({7'h00, irq}, 8'h00);
    chk(pen & pup, 8'hFF);
    foreach (rows[r]) begin
      xen = ~rows[r][1] & ~rows[r][3];
      ext = rows[r][5];
      for (int k = 0; k < 5; k++) wr(k, rows[r][k]);
      gap(6);
      d = rows[r][1];
      p = rows[r][3] & ~d;
      chk(p_oe, d);
      chk(p_out & d, rows[r][0] & d);
      chk(rdc, rows[r][2] & d);
      chk(pen, p);
      chk(pup & p, ~rows[r][4] & p);
      chk(rd_io, rows[r][6]);
      chk(rd_pin, rows[r][7]);
    end
    he = 8'h82;
    ho = 8'h80;
    hd = 8'h80;
    me = 8'hC1;
    mo = 8'hC1;
    gap(4);
    chk(p_oe & 8'hC3, 8'hC1);
    chk(p_out & 8'hC1, 8'h80);
    he = 8'h00;
    me = 8'h00;
    gap(4);
    chk(p_oe, 8'h0F);
    wr(1, 8'hFF);
    an = 8'hF0;
    xen = 8'h01;
    ext = 8'h01;
    gap(6);
    chk(p_oe, 8'h0F);
    chk(din & 8'hF0, 8'hF0);
    chk(rd_pin & 8'h01, 8'h01);
    chk(rd_io, 8'hC3);
    an = 8'h00;
    wr(1, 8'hFE);
    wr(3, 8'h00);
    wr(4, 8'h00);
    gap(10);
    wr(7, 8'hFF);
    wr(6, 8'h01);
    gap(8);
    pulse(1'b0, 3);
    gap(12);
    chk(flg & 8'h01, 8'h00);
    pulse(1'b0, 4);
    wait_flag(12);
    chk({7'h00, irq}, 8'h01);
    wr(7, 8'h00);
    chk(flg & 8'h01, 8'h01);
    wr(6, 8'h00);
    gap(1);
    chk({7'h00, irq}, 8'h00);
    wr(6, 8'h01);
    wr(7, 8'h01);
    gap(1);
    chk(flg & 8'h01, 8'h00);
    sm = 1'b1;
    gap(4);
    chk({7'h00, rc}, 8'h01);
    pulse(1'b0, 320);
    gap(1000);
    chk(flg & 8'h01, 8'h00);
    pulse(1'b0, 1000);
    wait_flag(400);
    gap(4);
    chk({7'h00, rc}, 8'h00);
    sm = 1'b0;
    final_report;
  end
endmodule
